// >>> logic/eac_consts.svh
// Contract
// - eeprom addressed linearly by 8-bit address, 0 to 255; address starts undefined.
// - unused high address bits read zero for memories under 256 bytes.
// - data register sources programming and receives read bytes.
// - control bits 7 and 6 are read-only zero.
// - mode 00 atomic 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms, 11 reserved.
// - mode bit writes ignored while busy.
// - reset clears mode bits unless programming is in progress.
// - ready interrupt requested when enabled, globally enabled, and memory ready.
// - master program enable self-clears four cycles after being set.
// - program enable write ignored when master enable is zero.
// - accepted program enable starts operation and stalls cpu two cycles.
// - program enable stays set as busy until programming time elapses.
// - flash, fuse and lock programming blocked while eeprom busy.
// - read strobe fetches byte immediately and stalls cpu four cycles; code stalls two cycles when a program enable is accepted in the same write.
// - no read and no address change while programming.
// - 8-bit scratch register, reset zero, no side effects.
`ifndef EAC_CONSTS_SVH
`define EAC_CONSTS_SVH

`define EAC_OFS_SCRATCH  8'h1e
`define EAC_OFS_CTRL     8'h1f
`define EAC_OFS_DATA     8'h20
`define EAC_OFS_ADDR     8'h21

`define EAC_BIT_READ     0
`define EAC_BIT_PROG     1
`define EAC_BIT_MASTER   2
`define EAC_BIT_RIE      3
`define EAC_BIT_PM_LO    4
`define EAC_BIT_PM_HI    5

`define EAC_RST_BYTE     8'h00
`define EAC_ERASED_BYTE  8'hff

`define EAC_CLK_HZ       10000000
`define EAC_T_ATOMIC_US  3400
`define EAC_T_SPLIT_US   1800
`define EAC_CYC_ATOMIC   ((`EAC_T_ATOMIC_US * (`EAC_CLK_HZ / 1000000)))
`define EAC_CYC_SPLIT    ((`EAC_T_SPLIT_US * (`EAC_CLK_HZ / 1000000)))
`define EAC_MASTER_CYC   4
`define EAC_PROG_STALL   2
`define EAC_READ_STALL   4

`endif

// >>> logic/eac_pkg.sv
`default_nettype none
package eac_pkg;
  typedef enum logic [1:0] {
    EAC_PM_ATOMIC = 2'b00,
    EAC_PM_ERASE  = 2'b01,
    EAC_PM_WRITE  = 2'b10,
    EAC_PM_RSVD   = 2'b11
  } eac_mode_t;
  typedef enum logic [0:0] {
    EAC_IDLE = 1'b0,
    EAC_BUSY = 1'b1
  } eac_state_t;
endpackage
`default_nettype wire

// >>> logic/eac_stall.sv
`include "eac_consts.svh"
`default_nettype none
// ==========================================
// cpu stall counter
module eac_stall (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic [2:0] cycles,
  output logic            stall
);
  logic [2:0] cnt_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
    end else if (load) begin
      cnt_r <= cycles;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end
  assign stall = load || (cnt_r != 3'h0);
endmodule
`default_nettype wire

// >>> logic/eac_top.sv
`include "eac_consts.svh"
`default_nettype none
module eac_top #(
  parameter int unsigned CYC_ATOMIC = `EAC_CYC_ATOMIC,
  parameter int unsigned CYC_SPLIT  = `EAC_CYC_SPLIT
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic [7:0]       io_addr,
  input  wire logic             io_wr,
  input  wire logic             io_rd,
  input  wire logic [7:0]       io_wdata,
  output logic      [7:0]       io_rdata,
  input  wire logic             global_irq_enable,
  input  wire logic             nv_power_reset,
  output logic                  ready_irq,
  output logic                  cpu_stall,
  output logic                  self_prog_block,
  output eac_pkg::eac_mode_t    active_mode
);
  import eac_pkg::*;

  // ==========================================
  // reset release
  logic rst_s1_r;
  logic rst_n;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // ==========================================
  // power reset release for the programming engine
  // the power reset lifts on a clock edge, so the engine never leaves reset mid-cycle
  logic nv_s1_r;
  logic nv_rst_n;
  always_ff @(posedge mclk or negedge nv_power_reset) begin
    if (!nv_power_reset) begin
      nv_s1_r  <= 1'b0;
      nv_rst_n <= 1'b0;
    end else begin
      nv_s1_r  <= 1'b1;
      nv_rst_n <= nv_s1_r;
    end
  end

  // ==========================================
  // decode
  wire wr_scratch = io_wr && (io_addr == `EAC_OFS_SCRATCH);
  wire wr_ctrl    = io_wr && (io_addr == `EAC_OFS_CTRL);
  wire wr_data    = io_wr && (io_addr == `EAC_OFS_DATA);
  wire wr_addr    = io_wr && (io_addr == `EAC_OFS_ADDR);

  // ==========================================
  // state
  logic [7:0]  mem_r [0:255];
  logic [7:0]  scratch_r;
  logic [7:0]  data_r;
  logic [7:0]  data_nxt;
  logic [7:0]  addr_r;
  logic [7:0]  prog_addr_r;
  logic [7:0]  prog_data_r;
  eac_mode_t   mode_r;
  eac_mode_t   op_mode_r;
  logic        rie_r;
  logic        master_r;
  logic [2:0]  master_cnt_r;
  eac_state_t  state_r;
  logic [15:0] prog_cnt_r;

  wire busy        = (state_r == EAC_BUSY);
  wire prog_req    = wr_ctrl && io_wdata[`EAC_BIT_PROG];
  wire prog_accept = prog_req && master_r && !busy && (mode_r != EAC_PM_RSVD);
  wire read_accept = wr_ctrl && io_wdata[`EAC_BIT_READ] && !busy;
  wire prog_done   = busy && (prog_cnt_r == 16'h0001);
  wire [15:0] prog_len = (mode_r == EAC_PM_ATOMIC) ? CYC_ATOMIC[15:0]
                                                   : CYC_SPLIT[15:0];

  // ==========================================
  // scratch, address, data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scratch_r <= `EAC_RST_BYTE;
    end else if (wr_scratch) begin
      scratch_r <= io_wdata;
    end
  end

  // address has no reset: powers up undefined
  always_ff @(posedge mclk) begin
    if (wr_addr && !busy) begin
      addr_r <= io_wdata;
    end
  end

  always_comb begin
    data_nxt = data_r;
    if (read_accept) begin
      data_nxt = mem_r[addr_r];
    end else if (wr_data) begin
      data_nxt = io_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= `EAC_RST_BYTE;
    end else begin
      data_r <= data_nxt;
    end
  end

  // ==========================================
  // control bits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rie_r <= 1'b0;
    end else if (wr_ctrl) begin
      rie_r <= io_wdata[`EAC_BIT_RIE];
    end
  end

  // mode survives reset while busy; when idle, cleared on every edge while reset is held and on the first edge after release
  logic mode_clr_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_clr_r <= 1'b1;
    end else begin
      mode_clr_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (mode_clr_r && !busy) begin
      mode_r <= EAC_PM_ATOMIC;
    end else if (rst_n && wr_ctrl && !busy) begin
      mode_r <= eac_mode_t'(io_wdata[`EAC_BIT_PM_HI:`EAC_BIT_PM_LO]);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      master_r     <= 1'b0;
      master_cnt_r <= 3'h0;
    end else if (wr_ctrl && io_wdata[`EAC_BIT_MASTER]) begin
      master_r     <= 1'b1;
      master_cnt_r <= 3'(`EAC_MASTER_CYC);
    end else if (master_cnt_r != 3'h0) begin
      master_cnt_r <= master_cnt_r - 3'h1;
      master_r     <= (master_cnt_r != 3'h1);
    end
  end

  // ==========================================
  // programming engine; runs on the power reset so a core reset cannot cut it
  always_ff @(posedge mclk or negedge nv_rst_n) begin
    if (!nv_rst_n) begin
      state_r    <= EAC_IDLE;
      prog_cnt_r <= 16'h0000;
    end else begin
      case (state_r)
        EAC_IDLE: begin
          if (prog_accept) begin
            state_r    <= EAC_BUSY;
            prog_cnt_r <= prog_len;
          end
        end
        EAC_BUSY: begin
          if (prog_done) begin
            state_r <= EAC_IDLE;
          end
          prog_cnt_r <= prog_cnt_r - 16'h0001;
        end
        default: begin
          state_r <= EAC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (prog_accept) begin
      prog_addr_r <= addr_r;
      prog_data_r <= data_r;
      op_mode_r   <= mode_r;
    end
  end

  // array change committed when the timed operation ends
  always_ff @(posedge mclk) begin
    if (prog_done) begin
      case (op_mode_r)
        EAC_PM_ATOMIC: mem_r[prog_addr_r] <= prog_data_r;
        EAC_PM_ERASE:  mem_r[prog_addr_r] <= `EAC_ERASED_BYTE;
        EAC_PM_WRITE:  mem_r[prog_addr_r] <= mem_r[prog_addr_r] & prog_data_r;
        default:       mem_r[prog_addr_r] <= mem_r[prog_addr_r];
      endcase
    end
  end

  // ==========================================
  // cpu stall
  wire [2:0] stall_len = prog_accept ? 3'(`EAC_PROG_STALL) : 3'(`EAC_READ_STALL);
  eac_stall u_stall (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .load   (prog_accept || read_accept),
    .cycles (stall_len),
    .stall  (cpu_stall)
  );

  // ==========================================
  // read back
  wire [7:0] ctrl_rd = {2'b00, mode_r, rie_r, master_r, busy, 1'b0};
  always_comb begin
    case (io_addr)
      `EAC_OFS_SCRATCH: io_rdata = scratch_r;
      `EAC_OFS_CTRL:    io_rdata = ctrl_rd;
      `EAC_OFS_DATA:    io_rdata = data_r;
      `EAC_OFS_ADDR:    io_rdata = addr_r;
      default:          io_rdata = 8'h00;
    endcase
  end

  assign ready_irq       = rie_r && global_irq_enable && !busy;
  assign self_prog_block = busy;
  assign active_mode     = mode_r;
endmodule
`default_nettype wire

// >>> verif/eac_core_model.sv
`default_nettype none
module eac_core_model (
  input  wire logic       mclk,
  input  wire logic       cpu_stall,
  input  wire logic [7:0] io_rdata,
  output logic      [7:0] io_addr,
  output logic            io_wr,
  output logic      [7:0] io_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    io_addr = 8'h00;
    io_wr = 1'b0;
    io_wdata = 8'h00;
  end
  // one register access; waits while the core is halted
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    repeat (8) begin
      @(negedge mclk);
      if (cpu_stall !== 1'b1) break;
    end
    @(posedge mclk);
    io_addr <= a;
    io_wr <= w;
    io_wdata <= d;
    @(negedge mclk);
    q = io_rdata;
    @(posedge mclk);
    io_wr <= 1'b0;
    // return off the edge so callers see settled outputs
    @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// >>> verif/eac_top_assertions.sv
`include "eac_consts.svh"
`default_nettype none
module eac_top_chk #(
  parameter int unsigned CYC_ATOMIC = 20,
  parameter int unsigned CYC_SPLIT  = 10
) (
  input wire logic               mclk,
  input wire logic               rstn,
  input wire logic [7:0]         io_addr,
  input wire logic               io_wr,
  input wire logic [7:0]         io_wdata,
  input wire logic [7:0]         io_rdata,
  input wire logic               global_irq_enable,
  input wire logic               ready_irq,
  input wire logic               cpu_stall,
  input wire logic               self_prog_block,
  input wire eac_pkg::eac_mode_t active_mode
);
  import eac_pkg::*;
  // ==========================================
  // helper counters
  logic [15:0] cnt_r;
  logic [2:0]  age_r;
  wire         ctl_w = io_wr && io_addr == `EAC_OFS_CTRL;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 16'h0;
      age_r <= 3'h7;
    end else begin
      cnt_r <= self_prog_block ? cnt_r + 16'h1 : 16'h0;
      age_r <= (ctl_w && io_wdata[2]) ? 3'h1 : age_r + {2'h0, age_r != 3'h7};
    end
  end
  // ==========================================
  // properties
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_two_stall;
    cpu_stall ##1 cpu_stall;
  endsequence
  chk_prog_stall: assert property ($rose(self_prog_block) |-> s_two_stall)
    else $error("program stall too short");
  chk_read_stall: assert property (
    ctl_w && io_wdata[0] && !self_prog_block |=> cpu_stall[*4])
    else $error("read stall too short");
  chk_master_window: assert property (
    $rose(self_prog_block) |-> $past(age_r) <= 3'h4)
    else $error("program started outside master window");
  chk_busy_len: assert property (
    $fell(self_prog_block) |->
      cnt_r == 16'(active_mode == EAC_PM_ATOMIC ? CYC_ATOMIC : CYC_SPLIT))
    else $error("busy length wrong");
  chk_mode_hold: assert property (self_prog_block |=> $stable(active_mode))
    else $error("mode changed while busy");
  chk_rsvd_zero: assert property (io_addr == `EAC_OFS_CTRL |-> io_rdata[7:6] == 2'b00)
    else $error("reserved bits not zero");
  chk_block_flag: assert property (
    io_addr == `EAC_OFS_CTRL |-> io_rdata[1] == self_prog_block)
    else $error("block differs from busy");
  chk_irq_level: assert property (
    io_addr == `EAC_OFS_CTRL |->
      ready_irq == (io_rdata[3] && global_irq_enable && !self_prog_block))
    else $error("ready interrupt wrong");
  chk_scratch_wr: assert property (
    io_wr && io_addr == `EAC_OFS_SCRATCH |=>
      (io_addr == `EAC_OFS_SCRATCH |-> io_rdata == $past(io_wdata)))
    else $error("scratch write lost");
endmodule
bind eac_top eac_top_chk #(.CYC_ATOMIC(CYC_ATOMIC), .CYC_SPLIT(CYC_SPLIT)) u_chk (
  .mclk              (mclk),
  .rstn              (rstn),
  .io_addr           (io_addr),
  .io_wr             (io_wr),
  .io_wdata          (io_wdata),
  .io_rdata          (io_rdata),
  .global_irq_enable (global_irq_enable),
  .ready_irq         (ready_irq),
  .cpu_stall         (cpu_stall),
  .self_prog_block   (self_prog_block),
  .active_mode       (active_mode)
);
`default_nettype wire

// >>> verif/tb_top.sv
`include "eac_consts.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic               mclk = 1'b0;
  logic               rstn = 1'b0;
  logic               nv_rst_n = 1'b0;
  logic               gie = 1'b1;
  logic [7:0]         io_addr;
  logic [7:0]         io_wdata;
  logic [7:0]         io_rdata;
  logic               io_wr;
  logic               ready_irq;
  logic               cpu_stall;
  logic               spb;
  eac_pkg::eac_mode_t act_mode;
  logic [7:0]         q;
  logic [1:0]         md;
  logic               bz;
  int                 errors = 0;
  int                 n_compared = 0;
  int                 n;
  logic [7:0]         dat [4] = '{8'h5a, 8'h5a, 8'hc3, 8'h99};
  logic [7:0]         exp [4] = '{8'h5a, 8'hff, 8'hc3, 8'hc3};
  always #50 mclk = ~mclk;
  eac_core_model u_core (.mclk(mclk), .cpu_stall(cpu_stall), .io_rdata(io_rdata),
    .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata));
  eac_top #(.CYC_ATOMIC(20), .CYC_SPLIT(10)) u_dut (.mclk(mclk), .rstn(rstn),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(1'b0), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .global_irq_enable(gie), .nv_power_reset(nv_rst_n),
    .ready_irq(ready_irq), .cpu_stall(cpu_stall), .self_prog_block(spb),
    .active_mode(act_mode));
  // ==========================================
  // checking tasks
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    u_core.acc(a, 1'b0, 8'h00, q);
    chk(nm, e, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_core.acc(a, 1'b1, d, q);
  endtask
  task automatic wrap_up;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    nv_rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rdc("ctrl", `EAC_OFS_CTRL, 8'h00);
    rdc("data", `EAC_OFS_DATA, 8'h00);
    rdc("scratch", `EAC_OFS_SCRATCH, 8'h00);
    rdc("unmapped", 8'h40, 8'h00);
    wr(`EAC_OFS_SCRATCH, 8'ha5);
    rdc("scratch", `EAC_OFS_SCRATCH, 8'ha5);
    wr(`EAC_OFS_CTRL, 8'h02);
    chk("no master", 8'h00, {7'h0, spb});
    wr(`EAC_OFS_CTRL, 8'h04);
    repeat (5) @(posedge mclk);
    wr(`EAC_OFS_CTRL, 8'h02);
    chk("late prog", 8'h00, {7'h0, spb});
    wr(`EAC_OFS_ADDR, 8'h10);
    for (int m = 0; m < 4; m++) begin
      md = m[1:0];
      bz = (m != 3);
      wr(`EAC_OFS_CTRL, {2'b00, md, 4'h8});
      wr(`EAC_OFS_DATA, dat[m]);
      wr(`EAC_OFS_CTRL, {2'b00, md, 4'hc});
      wr(`EAC_OFS_CTRL, {2'b00, md, 4'ha});
      chk("busy", {7'h0, bz}, {7'h0, spb});
      chk("irq busy", {7'h0, !bz}, {7'h0, ready_irq});
      wr(`EAC_OFS_CTRL, 8'h3a);
      chk("mode", {6'h0, md}, {6'h0, act_mode});
      wr(`EAC_OFS_ADDR, 8'h33);
      rdc("addr", `EAC_OFS_ADDR, bz ? 8'h10 : 8'h33);
      wr(`EAC_OFS_ADDR, 8'h10);
      q = 8'hff;
      for (n = 0; n < 40 && q[1] !== 1'b0; n++) begin
        u_core.acc(`EAC_OFS_CTRL, 1'b0, 8'h00, q);
      end
      if (n == 40) begin
        errors++;
        wrap_up();
      end
      chk("irq ready", 8'h01, {7'h0, ready_irq});
      wr(`EAC_OFS_CTRL, 8'h09);
      rdc("mem", `EAC_OFS_DATA, exp[m]);
    end
    @(posedge mclk);
    gie <= 1'b0;
    @(negedge mclk);
    chk("irq gie", 8'h00, {7'h0, ready_irq});
    wr(`EAC_OFS_CTRL, 8'h00);
    chk("irq off", 8'h00, {7'h0, ready_irq});
    wrap_up();
  end
endmodule
`default_nettype wire
